//--- design/resc_pkg.sv
// package: constants for the regulator enable and soft-start block
//----------------------------------------------------------------------
// Functional notes
// - enable low: shut down, no register access
// - other options keep registers while enable low
// - options 04, 24, 042 clear registers
// - power-on reset restores all register defaults
// - discharge load when control bit set and output off, enable pin high or low
// - enable rise with selected bit starts soft-start
// - ramp reference, no sync rectification in soft-start
// - 16 limit cycles: tristate, retry after 1700 ms
// - options other than 01, 05 reset both output enables high
// - options 01, 05 reset enables to 10
// - option 03 forces voltage select low internally
// - output follows selected enable bit, enable pin
// - mode bit high forces fixed-frequency switching
// - serial link up to 3.4 Mbps, outside block
// - select low picks setpoint 0, high setpoint 1
//----------------------------------------------------------------------
package resc_pkg;
    // register offsets
    localparam logic [7:0] OFS_SETPOINT_0 = 8'h00;
    localparam logic [7:0] OFS_SETPOINT_1 = 8'h01;
    localparam logic [7:0] OFS_CONTROL = 8'h02;
    localparam logic [7:0] OFS_STATUS = 8'h03;
    // field positions inside a setpoint register
    localparam int BIT_OUT_EN = 7;
    localparam int BIT_MODE = 6;
    // field positions inside the control register
    localparam int BIT_DISCHARGE = 7;
    // reset values
    localparam logic [7:0] RST_SETPOINT_0 = 8'h80;
    localparam logic [7:0] RST_SETPOINT_1 = 8'h80;
    localparam logic [7:0] RST_CONTROL = 8'h80;
    // part option codes, hex digits as printed
    localparam logic [11:0] OPT_01 = 12'h001;
    localparam logic [11:0] OPT_03 = 12'h003;
    localparam logic [11:0] OPT_04 = 12'h004;
    localparam logic [11:0] OPT_05 = 12'h005;
    localparam logic [11:0] OPT_24 = 12'h024;
    localparam logic [11:0] OPT_042 = 12'h042;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int RETRY_WAIT_MS = 1700;
    localparam int RETRY_CYCLES = RETRY_WAIT_MS * (CLK_HZ / 1000);
    localparam int SS_STEP_NS = 1000;
    localparam int SS_STEP_CYCLES = (SS_STEP_NS * (CLK_HZ / 1000_000)
                                     + 999) / 1000;
    localparam int LIMIT_RUN = 16;
    // regulator states
    typedef enum logic [1:0] {
        ST_OFF = 2'b00,
        ST_SOFT = 2'b01,
        ST_RUN = 2'b10,
        ST_WAIT = 2'b11
    } resc_state_t;
endpackage

//--- design/resc_top.sv
// module: enable, retention, soft-start and retry sequencing
`timescale 1ns/1ps
module resc_top #(
    parameter logic [11:0] PART_OPTION = 12'h000,
    parameter int RETRY_CYC = resc_pkg::RETRY_CYCLES,
    parameter int SS_STEP_CYC = resc_pkg::SS_STEP_CYCLES
) (
    input wire logic ref_clk_i, // 10 MHz system clock
    input wire logic reset_i, // power-on reset, synchronous
    input wire logic enable_pin_i, // enable pin, asynchronous
    input wire logic voltage_select_pin_i, // select pin, asynchronous
    input wire logic cur_limit_i, // limit reached this cycle
    input wire logic cycle_end_i, // toggles rise once per cycle
    input wire logic [7:0] addr_i, // register address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    output logic regulator_on_o, // switching active
    output logic softstart_o, // soft-start ramp running
    output logic sync_rect_en_o, // synchronous rectifier allowed
    output logic switch_hiz_o, // switching node three-state
    output logic discharge_o, // output discharge load on
    output logic pwm_force_o, // fixed-frequency switching
    output logic setpoint_sel_o, // active setpoint index
    output logic [5:0] reference_o // ramped reference code
);
    import resc_pkg::*;

    //------------------------------------------------------------------
    // elaboration checks
    //------------------------------------------------------------------
    if (RETRY_CYC < 2 || SS_STEP_CYC < 1) begin : g_bad
        $error("resc_top: retry or step count too small");
    end

    //------------------------------------------------------------------
    // option decode
    //------------------------------------------------------------------
    // options that clear registers while enable is low
    localparam bit CLR_ON_DIS = (PART_OPTION == OPT_04) ||
        (PART_OPTION == OPT_24) || (PART_OPTION == OPT_042);
    // options whose second output enable resets low
    localparam bit EN1_LOW = (PART_OPTION == OPT_01) ||
        (PART_OPTION == OPT_05);
    localparam bit SEL_TIED = (PART_OPTION == OPT_03);
    // setpoint 1 reset value with the option applied
    localparam logic [7:0] RST_SP1 = EN1_LOW ?
        (RST_SETPOINT_1 & 8'h7F) : RST_SETPOINT_1;

    //------------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------------
    logic [1:0] en_sync; // enable pin stages
    logic [1:0] sel_sync; // select pin stages
    logic [1:0] cl_sync; // current limit stages
    logic [1:0] ce_sync; // cycle end stages
    logic ce_last; // previous synced cycle end

    // two flops per pin, first stage read only by second
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            en_sync <= 2'h0;
            sel_sync <= 2'h0;
            cl_sync <= 2'h0;
            ce_sync <= 2'h0;
            ce_last <= 1'b0;
        end else begin
            en_sync <= {en_sync[0], enable_pin_i};
            sel_sync <= {sel_sync[0], voltage_select_pin_i};
            cl_sync <= {cl_sync[0], cur_limit_i};
            ce_sync <= {ce_sync[0], cycle_end_i};
            ce_last <= ce_sync[1];
        end
    end

    logic en; // synced enable
    logic sel_seen; // select seen by modulator logic
    logic cyc_done; // one switching cycle finished
    assign en = en_sync[1];
    assign sel_seen = SEL_TIED ? 1'b0 : sel_sync[1];
    assign cyc_done = ce_sync[1] & ~ce_last;

    //------------------------------------------------------------------
    // register file
    //------------------------------------------------------------------
    logic [7:0] setpoint_reg_0; // setpoint 0 config
    logic [7:0] setpoint_reg_1; // setpoint 1 config
    logic [7:0] control; // control register
    logic [7:0] next_setpoint_reg_0;
    logic [7:0] next_setpoint_reg_1;
    logic [7:0] next_control;
    logic [7:0] next_rdata;
    logic [4:0] cl_cnt; // consecutive limit cycles
    resc_state_t state; // sequencer state

    // writes, option clearing and read mux
    always_comb begin
        next_setpoint_reg_0 = setpoint_reg_0;
        next_setpoint_reg_1 = setpoint_reg_1;
        next_control = control;
        next_rdata = 8'h00;
        if (!en) begin
            // shut down: access refused, registers kept or cleared
            if (CLR_ON_DIS) begin
                next_setpoint_reg_0 = RST_SETPOINT_0;
                next_setpoint_reg_1 = RST_SP1;
                next_control = RST_CONTROL;
            end // otherwise contents held
        end else begin
            // writes only while enable high
            if (wr_i) begin // one access per clock, no stall
                unique case (addr_i)
                    OFS_SETPOINT_0: next_setpoint_reg_0 = wdata_i;
                    OFS_SETPOINT_1: next_setpoint_reg_1 = wdata_i;
                    OFS_CONTROL: next_control = wdata_i;
                    default: ;
                endcase
            end
            // reads, unmapped address gives zero
            if (rd_i) begin
                unique case (addr_i)
                    OFS_SETPOINT_0: next_rdata = setpoint_reg_0;
                    OFS_SETPOINT_1: next_rdata = setpoint_reg_1;
                    OFS_CONTROL: next_rdata = control;
                    OFS_STATUS: next_rdata = {state, 1'b0, cl_cnt};
                    default: next_rdata = 8'h00;
                endcase
            end
        end
    end

    // register update, power-on defaults
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            setpoint_reg_0 <= RST_SETPOINT_0;
            setpoint_reg_1 <= RST_SP1;
            control <= RST_CONTROL;
            rdata_o <= 8'h00;
        end else begin
            setpoint_reg_0 <= next_setpoint_reg_0;
            setpoint_reg_1 <= next_setpoint_reg_1;
            control <= next_control;
            rdata_o <= next_rdata;
        end
    end

    //------------------------------------------------------------------
    // sequencer
    //------------------------------------------------------------------
    logic [7:0] sel_reg; // active setpoint register
    logic want_on; // output requested on
    assign sel_reg = sel_seen ? setpoint_reg_1 : setpoint_reg_0;
    assign want_on = en & sel_reg[BIT_OUT_EN];

    resc_state_t next_state;
    logic [31:0] tmr; // step and retry timer
    logic [31:0] next_tmr;
    logic [4:0] next_cl_cnt;
    logic [5:0] next_ref;
    logic next_on, next_ss, next_sr, next_hiz, next_dis, next_pwm;
    logic next_sel;

    // state, ramp and fault counting
    always_comb begin
        next_state = state;
        next_tmr = tmr;
        next_cl_cnt = cl_cnt;
        next_ref = reference_o;
        // limit run counting while switching
        if (state == ST_SOFT || state == ST_RUN) begin
            if (cyc_done) begin
                next_cl_cnt = cl_sync[1] ? cl_cnt + 5'h01 : 5'h00;
            end
        end
        unique case (state)
            ST_OFF: begin
                next_ref = 6'h00;
                next_tmr = 32'h0;
                next_cl_cnt = 5'h00;
                if (want_on) begin
                    next_state = ST_SOFT;
                end
            end
            ST_SOFT: begin
                // slow ramp of reference toward target
                if (tmr >= 32'(SS_STEP_CYC - 1)) begin
                    next_tmr = 32'h0;
                    if (reference_o < sel_reg[5:0]) begin
                        next_ref = reference_o + 6'h01;
                    end else begin
                        next_ref = sel_reg[5:0];
                        next_state = ST_RUN;
                    end
                end else begin
                    next_tmr = tmr + 32'h1;
                end
            end
            ST_RUN: begin
                next_ref = sel_reg[5:0];
                next_tmr = 32'h0;
            end
            ST_WAIT: begin
                next_ref = 6'h00;
                next_cl_cnt = 5'h00;
                if (tmr >= 32'(RETRY_CYC - 1)) begin
                    next_tmr = 32'h0;
                    next_state = ST_SOFT;
                end else begin
                    next_tmr = tmr + 32'h1;
                end
            end
        endcase
        // fault shutdown after a full run of limit cycles
        if ((state == ST_SOFT || state == ST_RUN) &&
            next_cl_cnt == 5'(LIMIT_RUN)) begin
            next_state = ST_WAIT;
            next_tmr = 32'h0;
            next_cl_cnt = 5'h00;
            next_ref = 6'h00;
        end
        // disable overrides everything
        if (!want_on) begin
            next_state = ST_OFF;
            next_tmr = 32'h0;
            next_cl_cnt = 5'h00;
            next_ref = 6'h00;
        end
        next_on = (next_state == ST_SOFT) || (next_state == ST_RUN);
        next_ss = (next_state == ST_SOFT);
        next_sr = (next_state == ST_RUN);
        next_hiz = !next_on;
        next_dis = control[BIT_DISCHARGE] & !want_on;
        next_pwm = sel_reg[BIT_MODE];
        next_sel = sel_seen;
    end

    // sequencer registers, every output from a flop
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            state <= ST_OFF;
            tmr <= 32'h0;
            cl_cnt <= 5'h00;
            reference_o <= 6'h00;
            regulator_on_o <= 1'b0;
            softstart_o <= 1'b0;
            sync_rect_en_o <= 1'b0;
            switch_hiz_o <= 1'b1;
            discharge_o <= 1'b0;
            pwm_force_o <= 1'b0;
            setpoint_sel_o <= 1'b0;
        end else begin
            state <= next_state;
            tmr <= next_tmr;
            cl_cnt <= next_cl_cnt;
            reference_o <= next_ref;
            regulator_on_o <= next_on;
            softstart_o <= next_ss;
            sync_rect_en_o <= next_sr;
            switch_hiz_o <= next_hiz;
            discharge_o <= next_dis;
            pwm_force_o <= next_pwm;
            setpoint_sel_o <= next_sel;
        end
    end

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    property p_no_access_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!en && rd_i) |=> (rdata_o == 8'h00);
    endproperty
    a_no_access_off: assert property (p_no_access_off)
        else $error("read answered while disabled");

    property p_keep;
        @(posedge ref_clk_i) disable iff (reset_i)
        (!CLR_ON_DIS && !en) |=> $stable(control);
    endproperty
    a_keep: assert property (p_keep)
        else $error("control lost while disabled");

    property p_clear;
        @(posedge ref_clk_i) disable iff (reset_i)
        (CLR_ON_DIS && !en) |=> (control == RST_CONTROL);
    endproperty
    a_clear: assert property (p_clear)
        else $error("control not cleared while disabled");

    property p_discharge;
        @(posedge ref_clk_i) disable iff (reset_i)
        1'b1 |=> (discharge_o ==
            $past(control[BIT_DISCHARGE] & !want_on));
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge load wrong");

    property p_start;
        @(posedge ref_clk_i) disable iff (reset_i)
        (state == ST_OFF && want_on) |=> softstart_o;
    endproperty
    a_start: assert property (p_start)
        else $error("soft-start not begun");

    property p_no_sr_ss;
        @(posedge ref_clk_i) disable iff (reset_i)
        softstart_o |-> !sync_rect_en_o;
    endproperty
    a_no_sr_ss: assert property (p_no_sr_ss)
        else $error("rectifier on during soft-start");

    property p_fault;
        @(posedge ref_clk_i) disable iff (reset_i)
        (state == ST_WAIT) |-> switch_hiz_o && !regulator_on_o;
    endproperty
    a_fault: assert property (p_fault)
        else $error("switching during retry wait");

    property p_off;
        @(posedge ref_clk_i) disable iff (reset_i)
        !want_on |=> !regulator_on_o && (state == ST_OFF);
    endproperty
    a_off: assert property (p_off)
        else $error("output on while disabled");

    property p_mode;
        @(posedge ref_clk_i) disable iff (reset_i)
        $rose(sel_reg[BIT_MODE]) |=> pwm_force_o;
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode bit not applied");

    property p_tied;
        @(posedge ref_clk_i) disable iff (reset_i)
        SEL_TIED |-> !setpoint_sel_o;
    endproperty
    a_tied: assert property (p_tied)
        else $error("select not tied low");
endmodule

//--- testbench/resc_host.sv
// host processor model: drives the enable and select pins and the register port
`timescale 1ns/1ps
module resc_host (
    input wire logic ref_clk_i, // system clock
    output logic enable_pin_o, // enable pin drive
    output logic voltage_select_pin_o, // select pin drive
    output logic [7:0] addr_o, // register address
    output logic [7:0] wdata_o, // write data
    output logic wr_o, // write strobe
    output logic rd_o // read strobe
);
    // idle bus, part disabled, select held low after power-up
    initial begin
        enable_pin_o = 1'b0;
        voltage_select_pin_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end
    // one-cycle write beside address and data
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge ref_clk_i);
        wr_o <= 1'b0;
    endtask
    // one-cycle read; data stands in the cycle after the strobe
    task automatic read_reg(input logic [7:0] a);
        @(posedge ref_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge ref_clk_i);
        rd_o <= 1'b0;
    endtask
    // pin levels change right after an edge
    task automatic set_pins(input logic e, input logic v);
        @(posedge ref_clk_i);
        enable_pin_o <= e;
        voltage_select_pin_o <= v;
    endtask
endmodule

//--- testbench/testbench.sv
// self-checking bench for the enable and soft-start sequencer
`timescale 1ns/1ps
module testbench;
    import resc_pkg::*;
    localparam int RT = 40; // shortened retry wait
    localparam int SS = 2; // ramp step length
    logic ref_clk_i, reset_i, cur_limit_i, cycle_end_i;
    logic enable_pin_i, voltage_select_pin_i, wr_i, rd_i;
    logic [7:0] addr_i, wdata_i, rdata_a, rdata_b;
    logic on_a, ss_a, sr_a, hiz_a, dis_a, pwm_a, sel_a, on_b, on_c, sel_c;
    logic [5:0] ref_a;
    int err_count = 0;
    int num_checks = 0;
    int sp[2][2]; // model setpoints: instance, index
    int ctl[2]; // model control register
    bit en_m, sel_m; // model pin levels
    int n; // cycles spent waiting
    logic [31:0] lfsr = 32'hCA9D;
    //------------------------------------------------------------------
    // instances: clearing option, keeping option and select-tied option
    //------------------------------------------------------------------
    resc_host i_host (.ref_clk_i(ref_clk_i), .enable_pin_o(enable_pin_i),
        .voltage_select_pin_o(voltage_select_pin_i), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
    resc_top #(.PART_OPTION(OPT_04), .RETRY_CYC(RT), .SS_STEP_CYC(SS))
    i_dut (.ref_clk_i, .reset_i, .enable_pin_i, .voltage_select_pin_i,
        .cur_limit_i, .cycle_end_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o(rdata_a), .regulator_on_o(on_a), .softstart_o(ss_a),
        .sync_rect_en_o(sr_a), .switch_hiz_o(hiz_a), .discharge_o(dis_a),
        .pwm_force_o(pwm_a), .setpoint_sel_o(sel_a), .reference_o(ref_a));
    resc_top #(.PART_OPTION(OPT_01), .RETRY_CYC(RT), .SS_STEP_CYC(SS))
    i_dut_keep (.ref_clk_i, .reset_i, .enable_pin_i, .voltage_select_pin_i,
        .cur_limit_i, .cycle_end_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o(rdata_b), .regulator_on_o(on_b), .softstart_o(),
        .sync_rect_en_o(), .switch_hiz_o(), .discharge_o(),
        .pwm_force_o(), .setpoint_sel_o(), .reference_o());
    // option with the select input tied low inside
    resc_top #(.PART_OPTION(OPT_03), .RETRY_CYC(RT), .SS_STEP_CYC(SS))
    i_dut_tied (.ref_clk_i, .reset_i, .enable_pin_i, .voltage_select_pin_i,
        .cur_limit_i, .cycle_end_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o(), .regulator_on_o(on_c), .softstart_o(),
        .sync_rect_en_o(), .switch_hiz_o(), .discharge_o(),
        .pwm_force_o(), .setpoint_sel_o(sel_c), .reference_o());
    //------------------------------------------------------------------
    // helpers
    //------------------------------------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // output wanted on by the model
    function automatic bit want(input int i);
        return en_m & sp[i][sel_m][7];
    endfunction
    task automatic final_report();
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // let synchronisers and registered outputs settle
    task automatic settle();
        repeat (6) @(posedge ref_clk_i);
        #1;
    endtask
    // bounded wait for soft-start (0) or run (1)
    task automatic wait_for(input bit which);
        n = 0;
        while ((which ? sr_a : ss_a) !== 1'b1) begin
            @(posedge ref_clk_i);
            #1;
            n++;
            if (n > 200) begin
                err_count++;
                $display("FAIL wait expected 1 seen 0");
                final_report();
            end
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.write_reg(a, d);
        for (int i = 0; i < 2; i++) begin
            if (en_m && a < 8'h02) sp[i][a[0]] = d;
            else if (en_m && a == OFS_CONTROL) ctl[i] = d;
        end
    endtask
    task automatic pins(input bit e, input bit v);
        i_host.set_pins(e, v);
        en_m = e;
        sel_m = v;
        if (!e) begin
            // clearing option drops to defaults while disabled
            sp[0] = '{RST_SETPOINT_0, RST_SETPOINT_1};
            ctl[0] = RST_CONTROL;
        end
        settle();
    endtask
    // read the map on the clearing and keeping instances; unmapped offset reads zero
    task automatic read_all();
        int e0, e1;
        for (int a = 0; a < 5; a++) begin
            if (a == 3) continue;
            i_host.read_reg(8'(a));
            #1;
            e0 = a < 2 ? sp[0][a] : (a == 2 ? ctl[0] : 0);
            e1 = a < 2 ? sp[1][a] : (a == 2 ? ctl[1] : 0);
            check("rdata_a", rdata_a, en_m ? 8'(e0) : 8'h00);
            check("rdata_b", rdata_b, en_m ? 8'(e1) : 8'h00);
        end
    endtask
    task automatic outs();
        check("on", on_a, want(0));
        check("on_keep", on_b, want(1));
        check("discharge", dis_a, ctl[0][7] & !want(0));
        check("pwm", pwm_a, sp[0][sel_m][6]);
        check("sel", sel_a, sel_m);
        check("hiz", hiz_a, !want(0));
        check("sel_tied", sel_c, 1'b0);
        check("on_tied", on_c, en_m & sp[1][0][7]);
    endtask
    // one switching cycle, limited or clean
    task automatic pulse(input bit lim);
        @(posedge ref_clk_i);
        cur_limit_i <= lim;
        cycle_end_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        cycle_end_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask
    //------------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------------
    initial begin
        reset_i = 1'b1;
        cur_limit_i = 1'b0;
        cycle_end_i = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        sp[0] = '{RST_SETPOINT_0, RST_SETPOINT_1};
        sp[1] = '{RST_SETPOINT_0, 8'h00};
        ctl = '{RST_CONTROL, RST_CONTROL};
        pins(1'b1, 1'b0);
        read_all();
        outs();
        pins(1'b1, 1'b1);
        outs();
        wr(OFS_SETPOINT_1, 8'h05);
        settle();
        outs();
        // soft-start ramps to code 5 with rectifier held off
        wr(OFS_SETPOINT_1, 8'h85);
        wait_for(1'b0);
        check("sync_soft", sr_a, 1'b0);
        wait_for(1'b1);
        check("ramp_end", ref_a, 8'h05);
        check("ss_done", ss_a, 1'b0);
        // a clean cycle restarts the limit count
        repeat (15) pulse(1'b1);
        pulse(1'b0);
        repeat (15) pulse(1'b1);
        settle();
        outs();
        pulse(1'b1);
        check("hiz_fault", hiz_a, 1'b1);
        check("on_fault", on_a, 1'b0);
        @(posedge ref_clk_i);
        cur_limit_i <= 1'b0;
        wait_for(1'b0);
        check("retry_wait", n >= RT - 10, 1'b1);
        wait_for(1'b1);
        // random setpoints, control and pin levels
        for (int k = 0; k < 12; k++) begin
            lfsr = lfsr_next(lfsr);
            pins(1'b1, lfsr[26]);
            wr(OFS_SETPOINT_0, lfsr[7:0]);
            wr(OFS_SETPOINT_1, lfsr[15:8]);
            wr(OFS_CONTROL, lfsr[23:16]);
            pins(lfsr[24] | lfsr[25], lfsr[26]);
            outs();
            read_all();
        end
        // writes refused while disabled; retention differs per option
        pins(1'b1, 1'b0);
        wr(OFS_CONTROL, 8'h3C);
        pins(1'b0, 1'b0);
        wr(OFS_CONTROL, 8'h5A);
        read_all();
        outs();
        pins(1'b1, 1'b0);
        read_all();
        // power-on reset in mid-run: every option back to defaults
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        sp[0] = '{RST_SETPOINT_0, RST_SETPOINT_1};
        sp[1] = '{RST_SETPOINT_0, 8'h00};
        ctl = '{RST_CONTROL, RST_CONTROL};
        settle();
        read_all();
        outs();
        final_report();
    end
endmodule
